// ---- bench/testbench.sv ----
/*
 * Self-checking bench for the bus fault status unit: sticky flags, actions,
 * fault address, imprecise pending and the APB register slave with its interrupt.
 * Assumes the unit answers APB on its own and fault events are one-cycle pulses.
 */
`timescale 1ns/10ps
module testbench;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    fault_status_pkg::fault_events_s events = '0;
    logic [7:0] current_priority = 8'h00;
    logic imprecise_handler_entry = 1'b0;
    fault_status_pkg::fault_actions_s actions;
    logic [3:0] fault_flags;
    logic [31:0] bus_fault_address;
    logic irq;
    int fail_count = 0;
    int n_tests = 0;
    logic [3:0] exp_flags = 4'h0;
    logic [31:0] exp_addr = 32'h00000000;
    logic [31:0] rdata;
    logic err;
    logic [3:0] kinds;
    logic [31:0] wdata;

    // A 50 ns period gives the 20 MHz bus clock.
    always #25 pclk = ~pclk;

    bus_fault_status u_bus_fault_status (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .events(events), .current_priority(current_priority), .imprecise_handler_entry(imprecise_handler_entry),
        .actions(actions), .fault_flags(fault_flags), .bus_fault_address(bus_fault_address), .irq(irq));

    // ----------------------------------------------------------------
    // Expectation helpers and checking
    // ----------------------------------------------------------------
    // The flags read back in bits 12 down to 9, everything else is zero.
    function automatic logic [31:0] status_word(input logic [3:0] f);
        return {19'h00000, f, 9'h000};
    endfunction : status_word

    function automatic fault_status_pkg::fault_events_s make_events(input logic [3:0] k, input logic [31:0] a);
        fault_status_pkg::fault_events_s e;
        e.stack_entry_fault = k[3];
        e.unstack_return_fault = k[2];
        e.imprecise_error = k[1];
        e.precise_error = k[0];
        e.precise_address = a;
        return e;
    endfunction : make_events

    task automatic end_of_test;
        $display("TB: %0d comparisons, %0d mismatches", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // ----------------------------------------------------------------
    // Drivers
    // ----------------------------------------------------------------
    // One APB transfer; acc_ev is driven during the access phase so a fault
    // can land on the very edge that commits a clear.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input fault_status_pkg::fault_events_s acc_ev);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        events <= acc_ev;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            chk("pready", pready, 32'h00000001);
            end_of_test();
        end else begin
            rdata = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            events <= '0;
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, '0);
    endtask : wr

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h00000000, '0);
    endtask : rd

    // Pulse for one cycle, then stop in the middle of the cycle that shows the result.
    task automatic pulse(input fault_status_pkg::fault_events_s e);
        @(posedge pclk);
        events <= e;
        @(posedge pclk);
        events <= '0;
        @(negedge pclk);
    endtask : pulse

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(47));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("flags after reset", fault_flags, 32'h0);
        rd(fault_status_pkg::STATUS_ADDR);
        chk("status after reset", rdata, 32'h0);
        rd(fault_status_pkg::ADDRESS_ADDR);
        chk("address after reset", rdata, 32'h0);
        // Random fault mixes, all four kinds first, with zero and random clears between them.
        for (int i = 0; i < 24; i++) begin
            kinds = (i == 0) ? 4'hf : 4'($urandom());
            wdata = $urandom();
            pulse(make_events(kinds, wdata));
            exp_flags = exp_flags | kinds;
            if (kinds[0]) begin
                exp_addr = wdata;
            end
            chk("flags", fault_flags, exp_flags);
            chk("fault address", bus_fault_address, exp_addr);
            chk("pointer adjust", actions.stack_pointer_adjust, kinds[3]);
            chk("chain", actions.chain_to_handler, kinds[2]);
            chk("context save", actions.context_save, 1'b0);
            if (i % 3 != 0) begin
                wdata = (i % 3 == 1) ? 32'h00000000 : $urandom();
                wr(fault_status_pkg::STATUS_ADDR, wdata);
                exp_flags = exp_flags & ~wdata[12:9];
            end
            rd(fault_status_pkg::STATUS_ADDR);
            chk("status", rdata, status_word(exp_flags));
        end
        // A stacking fault on the edge of a clear-all must survive it.
        apb(1'b1, fault_status_pkg::STATUS_ADDR, 32'h00001e00, make_events(4'h8, 32'h0));
        exp_flags = 4'h8;
        @(negedge pclk);
        chk("set beats clear", fault_flags, exp_flags);
        chk("irq masked off", irq, 1'b0);
        wr(fault_status_pkg::MASK_ADDR, 32'hffffffff);
        chk("mask write error", err, 1'b0);
        rd(fault_status_pkg::MASK_ADDR);
        chk("mask", rdata, 32'h00001e00);
        repeat (2) @(negedge pclk);
        chk("irq raised", irq, 1'b1);
        wr(fault_status_pkg::STATUS_ADDR, 32'h00001e00);
        exp_flags = 4'h0;
        repeat (2) @(negedge pclk);
        chk("irq cleared", irq, 1'b0);
        // Imprecise fault held back while the current priority is not below the bus fault's.
        wr(fault_status_pkg::PRIORITY_ADDR, 32'h00000040);
        rd(fault_status_pkg::PRIORITY_ADDR);
        chk("priority", rdata, 32'h00000040);
        @(posedge pclk);
        current_priority <= 8'h40;
        pulse(make_events(4'h2, 32'h0));
        repeat (3) @(negedge pclk);
        chk("activate at equal priority", actions.imprecise_activate, 1'b0);
        pulse(make_events(4'h1, 32'h12345678));
        exp_addr = 32'h12345678;
        chk("imprecise and precise", fault_flags, 32'h3);
        @(posedge pclk);
        current_priority <= 8'h41;
        repeat (3) @(negedge pclk);
        chk("activate when lower", actions.imprecise_activate, 1'b1);
        @(posedge pclk);
        imprecise_handler_entry <= 1'b1;
        @(posedge pclk);
        imprecise_handler_entry <= 1'b0;
        repeat (3) @(negedge pclk);
        chk("activate after entry", actions.imprecise_activate, 1'b0);
        chk("flags after entry", fault_flags, 32'h3);
        // Read-only address register and an unmapped place.
        wr(fault_status_pkg::ADDRESS_ADDR, 32'hdeadbeef);
        rd(fault_status_pkg::ADDRESS_ADDR);
        chk("address read only", rdata, exp_addr);
        wr(12'h010, 32'hffffffff);
        chk("unmapped write error", err, 1'b1);
        rd(12'h010);
        chk("unmapped read error", err, 1'b1);
        chk("unmapped read data", rdata, 32'h0);
        end_of_test();
    end
endmodule : testbench

// ---- src/bus_fault_status.sv ----
/*
 * Bus fault status unit: sticky stacking, unstacking, imprecise and
 * precise data bus error flags, the fault address capture, imprecise
 * fault pending and activation, and an APB register slave with an
 * interrupt built from the flags and a mask.
 * Assumes fault event pulses come from logic on pclk, and that the
 * APB master follows the usual setup and access phases.
 */
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps

// Operation
// RQ1: Set stacking flag when exception-entry stacking hits one or more bus faults.
// RQ2: On stacking fault still adjust stack pointer, never load fault address.
// RQ3: Set unstacking flag when return unstacking hits one or more bus faults.
// RQ4: Unstacking fault chains to handler: no pointer adjust, no save, no address.
// RQ5: Set imprecise flag on unrelated-return data error, never load fault address.
// RQ6: Imprecise fault pends while current priority outranks bus fault priority.
// RQ7: A precise fault before imprecise handler entry leaves both flags set.
// RQ8: Precise flag reads zero until a precise data bus error occurs.
// RQ9: Flags reset to zero; writing one clears, writing zero leaves unchanged.
// RQ10: Flags stay set until cleared; a same-cycle hardware set beats the clear.
module bus_fault_status (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire fault_status_pkg::fault_events_s events,
    input wire logic [7:0] current_priority,
    input wire logic imprecise_handler_entry,
    output fault_status_pkg::fault_actions_s actions,
    output logic [3:0] fault_flags,
    output logic [31:0] bus_fault_address,
    output logic irq
);

    fault_status_pkg::unit_state_s s;
    fault_status_pkg::unit_state_s next_s;
    logic [3:0] flags;
    logic [3:0] flag_set;
    logic [3:0] flag_clear;
    logic setup;
    logic access;
    logic wr;
    logic mapped;
    logic [31:0] read_value;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // Registers answer with no wait state: the access phase sees pready.
    assign setup = psel & ~penable;
    assign access = psel & penable & s.pready;
    assign wr = access & pwrite & ~s.pslverr;
    assign mapped = (paddr == fault_status_pkg::STATUS_ADDR) || (paddr == fault_status_pkg::MASK_ADDR) ||
                    (paddr == fault_status_pkg::ADDRESS_ADDR) || (paddr == fault_status_pkg::PRIORITY_ADDR);

    // Read multiplexer; unused bits read as zero.
    always_comb begin
        read_value = fault_status_pkg::READ_ZERO;
        unique case (paddr)
            fault_status_pkg::STATUS_ADDR: begin
                read_value[fault_status_pkg::FLAG_LSB +: fault_status_pkg::FLAG_COUNT] = flags;
            end
            fault_status_pkg::MASK_ADDR: begin
                read_value[fault_status_pkg::FLAG_LSB +: fault_status_pkg::FLAG_COUNT] = s.mask;
            end
            fault_status_pkg::ADDRESS_ADDR: begin
                read_value = s.bus_fault_address;
            end
            fault_status_pkg::PRIORITY_ADDR: begin
                read_value[7:0] = s.bus_fault_priority;
            end
            default: begin
                read_value = fault_status_pkg::READ_ZERO;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Flag set and clear terms
    // ------------------------------------------------------------
    // Each flag is raised by its own fault event and stays sticky.
    always_comb begin
        flag_set = 4'h0;
        flag_set[fault_status_pkg::FLAG_STACK] = events.stack_entry_fault; // RQ1
        flag_set[fault_status_pkg::FLAG_UNSTACK] = events.unstack_return_fault; // RQ3
        flag_set[fault_status_pkg::FLAG_IMPRECISE] = events.imprecise_error; // RQ5
        flag_set[fault_status_pkg::FLAG_PRECISE] = events.precise_error; // RQ8 RQ7
        flag_clear = 4'h0;
        if (wr && paddr == fault_status_pkg::STATUS_ADDR) begin
            flag_clear = pwdata[fault_status_pkg::FLAG_LSB +: fault_status_pkg::FLAG_COUNT]; // RQ9
        end
    end

    sticky_flags flag_bank (
        .pclk(pclk),
        .presetn(presetn),
        .set(flag_set),
        .clear(flag_clear),
        .flags(flags)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        // Stacking still moves the stack pointer even when it faults.
        next_s.actions.stack_pointer_adjust = events.stack_entry_fault; // RQ2
        // A failed unstack chains straight to the handler on the old frame.
        next_s.actions.chain_to_handler = events.unstack_return_fault; // RQ4
        next_s.actions.context_save = 1'b0; // RQ4
        // Only a precise error knows its address; the other faults leave it.
        if (events.precise_error) begin
            next_s.bus_fault_address = events.precise_address; // RQ8
        end
        // Pending is set by the event and dropped on handler entry; set wins.
        if (events.imprecise_error) begin
            next_s.imprecise_pending = 1'b1; // RQ6
        end else if (imprecise_handler_entry) begin
            next_s.imprecise_pending = 1'b0;
        end
        // Lower number means higher priority; activation waits for lower.
        next_s.actions.imprecise_activate = next_s.imprecise_pending &&
                                            (current_priority > s.bus_fault_priority); // RQ6
        if (wr && paddr == fault_status_pkg::MASK_ADDR) begin
            next_s.mask = pwdata[fault_status_pkg::FLAG_LSB +: fault_status_pkg::FLAG_COUNT];
        end
        if (wr && paddr == fault_status_pkg::PRIORITY_ADDR) begin
            next_s.bus_fault_priority = pwdata[7:0];
        end
        // Interrupt follows the flags one cycle later, which keeps irq a flop.
        next_s.irq = |(flags & s.mask);
        next_s.pready = setup;
        next_s.pslverr = setup & ~mapped;
        next_s.prdata = (setup && mapped && !pwrite) ? read_value : fault_status_pkg::READ_ZERO;
    end

    // All state is registered together.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.mask <= fault_status_pkg::MASK_RESET;
            s.bus_fault_priority <= fault_status_pkg::PRIORITY_RESET;
            s.bus_fault_address <= fault_status_pkg::ADDRESS_RESET;
            s.imprecise_pending <= 1'b0;
            s.prdata <= fault_status_pkg::READ_ZERO;
            s.pready <= 1'b0;
            s.pslverr <= 1'b0;
            s.irq <= 1'b0;
            s.actions <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign actions = s.actions;
    assign fault_flags = flags;
    assign bus_fault_address = s.bus_fault_address;
    assign irq = s.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_stack_fault;
        events.stack_entry_fault && !events.precise_error;
    endsequence

    sequence s_unstack_fault;
        events.unstack_return_fault && !events.precise_error && !events.stack_entry_fault;
    endsequence

    property p_stack_flag;
        @(posedge pclk) disable iff (!presetn)
        events.stack_entry_fault |=> flags[fault_status_pkg::FLAG_STACK];
    endproperty
    a_stack_flag: assert property (p_stack_flag) else $error("stacking flag not set"); // RQ1

    property p_stack_action;
        @(posedge pclk) disable iff (!presetn)
        s_stack_fault |=> actions.stack_pointer_adjust && $stable(bus_fault_address);
    endproperty
    a_stack_action: assert property (p_stack_action) else $error("stacking fault action wrong"); // RQ2

    property p_unstack_flag;
        @(posedge pclk) disable iff (!presetn)
        events.unstack_return_fault |=> flags[fault_status_pkg::FLAG_UNSTACK];
    endproperty
    a_unstack_flag: assert property (p_unstack_flag) else $error("unstacking flag not set"); // RQ3

    property p_unstack_chain;
        @(posedge pclk) disable iff (!presetn)
        s_unstack_fault |=>
            actions.chain_to_handler && !actions.stack_pointer_adjust && !actions.context_save &&
            $stable(bus_fault_address);
    endproperty
    a_unstack_chain: assert property (p_unstack_chain) else $error("unstacking fault did not chain"); // RQ4

    property p_imprecise_flag;
        @(posedge pclk) disable iff (!presetn)
        events.imprecise_error && !events.precise_error |=>
            flags[fault_status_pkg::FLAG_IMPRECISE] && $stable(bus_fault_address) && s.imprecise_pending;
    endproperty
    a_imprecise_flag: assert property (p_imprecise_flag) else $error("imprecise fault handling wrong"); // RQ5

    property p_pending_held;
        @(posedge pclk) disable iff (!presetn)
        s.imprecise_pending && !imprecise_handler_entry && (current_priority <= s.bus_fault_priority) |=>
            s.imprecise_pending && !actions.imprecise_activate;
    endproperty
    a_pending_held: assert property (p_pending_held) else $error("imprecise fault activated too early"); // RQ6

    property p_pending_activates;
        @(posedge pclk) disable iff (!presetn)
        s.imprecise_pending && !imprecise_handler_entry && (current_priority > s.bus_fault_priority) |=>
            actions.imprecise_activate;
    endproperty
    a_pending_activates: assert property (p_pending_activates) else $error("imprecise fault not activated"); // RQ6

    property p_both_flags;
        @(posedge pclk) disable iff (!presetn)
        s.imprecise_pending && flags[fault_status_pkg::FLAG_IMPRECISE] && events.precise_error &&
            (flag_clear == 4'h0) |=>
            flags[fault_status_pkg::FLAG_IMPRECISE] && flags[fault_status_pkg::FLAG_PRECISE];
    endproperty
    a_both_flags: assert property (p_both_flags) else $error("imprecise and precise flags not both set"); // RQ7

    property p_precise_address;
        @(posedge pclk) disable iff (!presetn)
        events.precise_error |=>
            flags[fault_status_pkg::FLAG_PRECISE] && (bus_fault_address == $past(events.precise_address));
    endproperty
    a_precise_address: assert property (p_precise_address) else $error("precise fault address not captured"); // RQ8

    property p_precise_quiet;
        @(posedge pclk) disable iff (!presetn)
        !flags[fault_status_pkg::FLAG_PRECISE] && !events.precise_error |=> !flags[fault_status_pkg::FLAG_PRECISE];
    endproperty
    a_precise_quiet: assert property (p_precise_quiet) else $error("precise flag set with no error"); // RQ8

    property p_w1c;
        @(posedge pclk) disable iff (!presetn)
        (flag_clear != 4'h0) && (flag_set == 4'h0) |=> ((flags & $past(flag_clear)) == 4'h0);
    endproperty
    a_w1c: assert property (p_w1c) else $error("write of one did not clear flag"); // RQ9

    property p_irq_level;
        @(posedge pclk) disable iff (!presetn)
        ((flags & s.mask) != 4'h0) ##1 ((flags & s.mask) != 4'h0) |-> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt low with unmasked flag"); // RQ10

    // ------------------------------------------------------------
    // Register bus checks
    // ------------------------------------------------------------
    // Each APB step is its own sequence so the answer is tied to the setup that asked for it.
    sequence s_setup_mapped;
        psel && !penable && mapped;
    endsequence

    sequence s_setup_unmapped;
        psel && !penable && !mapped;
    endsequence

    sequence s_status_read;
        psel && !penable && !pwrite && (paddr == fault_status_pkg::STATUS_ADDR);
    endsequence

    sequence s_priority_write;
        wr && (paddr == fault_status_pkg::PRIORITY_ADDR);
    endsequence

    property p_answer_mapped;
        @(posedge pclk) disable iff (!presetn)
        s_setup_mapped |=> pready && !pslverr;
    endproperty
    a_answer_mapped: assert property (p_answer_mapped) else $error("mapped access not answered cleanly");

    property p_refuse_unmapped;
        @(posedge pclk) disable iff (!presetn)
        s_setup_unmapped |=> pready && pslverr && (prdata == fault_status_pkg::READ_ZERO);
    endproperty
    a_refuse_unmapped: assert property (p_refuse_unmapped) else $error("unmapped access not refused");

    property p_pready_single;
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready;
    endproperty
    a_pready_single: assert property (p_pready_single) else $error("pready held past one cycle");

    property p_status_read;
        @(posedge pclk) disable iff (!presetn)
        s_status_read |=> (prdata[fault_status_pkg::FLAG_LSB +: fault_status_pkg::FLAG_COUNT] == $past(flags));
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read does not show the flags"); // RQ9

    property p_priority_write;
        @(posedge pclk) disable iff (!presetn)
        s_priority_write |=> (s.bus_fault_priority == $past(pwdata[7:0]));
    endproperty
    a_priority_write: assert property (p_priority_write) else $error("priority write not taken"); // RQ6

    // Only a precise error may move the captured address, whatever else happens.
    property p_address_hold;
        @(posedge pclk) disable iff (!presetn)
        !events.precise_error |=> $stable(bus_fault_address);
    endproperty
    a_address_hold: assert property (p_address_hold) else $error("fault address moved without precise error"); // RQ5

endmodule : bus_fault_status

// ---- src/fault_status_pkg.sv ----
/*
 * Shared constants and carrier types for the bus fault status unit.
 * Assumes a single pclk domain and a 32-bit APB register bus.
 */
package fault_status_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] STATUS_ADDR = 12'h000;
    localparam logic [11:0] MASK_ADDR = 12'h004;
    localparam logic [11:0] ADDRESS_ADDR = 12'h008;
    localparam logic [11:0] PRIORITY_ADDR = 12'h00c;

    // ------------------------------------------------------------
    // Flag layout: the four flags sit in status bits 12 down to 9
    // ------------------------------------------------------------
    localparam int FLAG_COUNT = 4;
    localparam int FLAG_LSB = 9;
    localparam int FLAG_PRECISE = 0;
    localparam int FLAG_IMPRECISE = 1;
    localparam int FLAG_UNSTACK = 2;
    localparam int FLAG_STACK = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [7:0] PRIORITY_RESET = 8'h00;
    localparam logic [31:0] ADDRESS_RESET = 32'h00000000;
    localparam logic [31:0] READ_ZERO = 32'h00000000;

    // Fault events reported by the exception and bus logic, one-cycle pulses.
    typedef struct packed {
        logic stack_entry_fault;
        logic unstack_return_fault;
        logic imprecise_error;
        logic precise_error;
        logic [31:0] precise_address;
    } fault_events_s;

    // Actions handed back to the exception sequencer.
    typedef struct packed {
        logic stack_pointer_adjust;
        logic chain_to_handler;
        logic context_save;
        logic imprecise_activate;
    } fault_actions_s;

    // State of the sticky flag bank.
    typedef struct packed {
        logic [3:0] flags;
    } flag_state_s;

    // State of the top-level unit.
    typedef struct packed {
        logic [3:0] mask;
        logic [7:0] bus_fault_priority;
        logic [31:0] bus_fault_address;
        logic imprecise_pending;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        fault_actions_s actions;
    } unit_state_s;

endpackage : fault_status_pkg

// ---- src/sticky_flags.sv ----
/*
 * Bank of sticky flags: hardware sets, software clears by writing one.
 * Assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/10ps
module sticky_flags (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] set,
    input wire logic [3:0] clear,
    output logic [3:0] flags
);

    fault_status_pkg::flag_state_s s;
    fault_status_pkg::flag_state_s next_s;

    // ------------------------------------------------------------
    // Flag update
    // ------------------------------------------------------------
    // The set term is ORed last so an event landing on a clear is kept.
    always_comb begin
        next_s = s;
        next_s.flags = (s.flags & ~clear) | set; // RQ9 RQ10
    end

    // Flags start clear out of reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.flags <= fault_status_pkg::FLAGS_RESET; // RQ9
        end else begin
            s <= next_s;
        end
    end

    assign flags = s.flags;

    property p_set_wins;
        @(posedge pclk) disable iff (!presetn)
        (set != 4'h0) |=> ((flags & $past(set)) == $past(set));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag set lost against clear"); // RQ10

    property p_zero_keeps;
        @(posedge pclk) disable iff (!presetn)
        (clear == 4'h0) |=> ((flags & $past(flags)) == $past(flags));
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("flag dropped without a clear"); // RQ9

endmodule : sticky_flags
